// file: common/dsr_link_if.sv
/*
 * Serial command link between host and display responder.
 * Assumes both ends share one clock; no tri-state lines.
 */
`timescale 1ns/100ps
interface dsr_link_if;
    logic csx_n;
    logic scl;
    logic sda;
    logic sdo;

    modport host (output csx_n, output scl, output sda, input sdo);
    modport dev  (input csx_n, input scl, input sda, output sdo);
endinterface

// file: common/dsr_pkg.sv
/*
 * Shared constants: command codes, status byte layouts and resets, link
 * framing and the host register map. Assumes nothing; imported by all modules but dsr_link_sva.
 */
package dsr_pkg;

    // status read command codes, 8-bit and 16-bit forms
    localparam logic [7:0]  DSR_CMD_PIXFMT      = 8'h0C;
    localparam logic [7:0]  DSR_CMD_IMGMODE     = 8'h0D;
    localparam logic [7:0]  DSR_CMD_SIGMODE     = 8'h0E;
    localparam logic [15:0] DSR_CMDW_PIXFMT     = 16'h0C00;
    localparam logic [15:0] DSR_CMDW_IMGMODE    = 16'h0D00;
    localparam logic [15:0] DSR_CMDW_SIGMODE    = 16'h0E00;

    // status byte reset values
    localparam logic [7:0]  DSR_RST_PIXFMT      = 8'h70;
    localparam logic [7:0]  DSR_RST_IMGMODE     = 8'h00;
    localparam logic [7:0]  DSR_RST_SIGMODE     = 8'h00;

    // defined bits of each status byte
    localparam logic [7:0]  DSR_MASK_PIXFMT     = 8'h70;
    localparam logic [7:0]  DSR_MASK_IMGMODE    = 8'h3F;
    localparam logic [7:0]  DSR_MASK_SIGMODE    = 8'hC0;

    // field positions
    localparam int          DSR_POS_COLFMT      = 4;
    localparam int          DSR_POS_INV         = 5;
    localparam int          DSR_POS_WHITE       = 4;
    localparam int          DSR_POS_BLACK       = 3;
    localparam int          DSR_POS_GAMMA       = 0;
    localparam int          DSR_POS_TEAR_LINE_ENABLED        = 7;
    localparam int          DSR_POS_TEMODE      = 6;

    // interface color format codes
    localparam logic [2:0]  DSR_FMT_16BPP       = 3'h5;
    localparam logic [2:0]  DSR_FMT_18BPP       = 3'h6;
    localparam logic [2:0]  DSR_FMT_24BPP       = 3'h7;

    // setting write port selectors
    localparam logic [1:0]  DSR_SEL_PIXFMT      = 2'h0;
    localparam logic [1:0]  DSR_SEL_IMGMODE     = 2'h1;
    localparam logic [1:0]  DSR_SEL_SIGMODE     = 2'h2;

    // link framing
    localparam logic [4:0]  DSR_BITS_WIDE       = 5'h10;
    localparam logic [4:0]  DSR_BITS_NARROW     = 5'h08;
    localparam logic [4:0]  DSR_BITS_PARAM      = 5'h08;
    localparam int          DSR_SCL_HALF        = 4;

    // host controller register map (byte addresses)
    localparam logic [3:0]  DSR_REG_CMD         = 4'h0;
    localparam logic [3:0]  DSR_REG_CFG         = 4'h4;
    localparam logic [3:0]  DSR_REG_STAT        = 4'h8;
    localparam logic [3:0]  DSR_REG_DATA        = 4'hC;
    localparam logic [1:0]  DSR_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  DSR_RESP_SLVERR     = 2'h2;

    // device responder states
    typedef enum logic [1:0] {
        DSR_DEV_IDLE = 2'b00,
        DSR_DEV_CMD  = 2'b01,
        DSR_DEV_RESP = 2'b10,
        DSR_DEV_SKIP = 2'b11
    } dsr_dev_st_type;

    // host link states
    typedef enum logic [1:0] {
        DSR_HST_IDLE = 2'b00,
        DSR_HST_LOW  = 2'b01,
        DSR_HST_HIGH = 2'b10
    } dsr_hst_st_type;

endpackage

// file: hw/dsr_dev.sv
/*
 * Status readback responder: keeps the three status bytes and answers
 * their read commands. Assumes synchronous link pins and scl levels of
 * at least two clocks.
 */
// Behaviour
// R1: command 0Ch or 0C00h reads pixel format
// R2: bits 6..4 give interface color format
// R3: resets give 70h, 00h, 00h
// R4: undefined status bits always read zero
// R5: command 0Dh or 0D00h reads image mode
// R6: bits 5,4,3: inversion, white, black forcing
// R7: bits 2..0 report selected gamma curve
// R8: command 0Eh or 0E00h reads signal mode
// R9: bit 7 reports tear line enabled
// R10: bit 6 reports tear line mode
// R11: reads answered in every power state
// R12: status byte is first parameter, host reads one
// R13: fields follow current settings, next read sees change
`timescale 1ns/100ps
module dsr_dev
    import dsr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // link to the host
    dsr_link_if.dev         lnk,
    // command form: 1 selects 16-bit serial words
    input  wire logic       cmd_wide_i,
    // setting updates from the write-command logic
    input  wire logic       set_valid_i,
    input  wire logic [1:0] set_sel_i,
    input  wire logic [7:0] set_data_i,
    input  wire logic       sw_reset_i,
    // current settings towards the display logic
    output logic      [2:0] interface_color_format_o,
    output logic            inversion_active_o,
    output logic            force_white_active_o,
    output logic            force_black_active_o,
    output logic      [2:0] gamma_curve_select_o,
    output logic            tear_line_enabled_o,
    output logic            tear_line_mode_o,
    // activity
    output logic            busy_o
);
    typedef struct packed {
        dsr_dev_st_type st;
        logic           scl;
        logic [4:0]     cnt;
        logic [7:0]     resp;
        logic [7:0]     pix;
        logic [7:0]     img;
        logic [7:0]     sig;
    } dsr_dev_type;

    dsr_dev_type q, d;

    logic        rise;
    logic        shift_en;
    logic [15:0] cmd_val;
    logic [15:0] word;
    logic [4:0]  cmd_bits;
    logic [1:0]  hit;

    // map a received word to a status selector; 2'h3 means not ours
    function automatic logic [1:0] dsr_decode(input logic [15:0] w,
                                              input logic        wide);
        logic [1:0] s;
        s = 2'h3;
        if (wide)
        begin
            if (w == DSR_CMDW_PIXFMT)  s = DSR_SEL_PIXFMT;  // R1
            if (w == DSR_CMDW_IMGMODE) s = DSR_SEL_IMGMODE; // R5
            if (w == DSR_CMDW_SIGMODE) s = DSR_SEL_SIGMODE; // R8
        end
        else
        begin
            if (w[7:0] == DSR_CMD_PIXFMT)  s = DSR_SEL_PIXFMT;  // R1
            if (w[7:0] == DSR_CMD_IMGMODE) s = DSR_SEL_IMGMODE; // R5
            if (w[7:0] == DSR_CMD_SIGMODE) s = DSR_SEL_SIGMODE; // R8
        end
        return s;
    endfunction

    // a format code outside the three defined ones is not stored
    function automatic logic dsr_fmt_ok(input logic [2:0] f);
        return (f == DSR_FMT_16BPP) || (f == DSR_FMT_18BPP) ||
               (f == DSR_FMT_24BPP);
    endfunction

    // command word assembles msb first while csx_n is low
    dsr_shift #(
        .W          (16)
    ) u_cmd (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .load_i     (lnk.csx_n),
        .load_val_i (16'h0000),
        .shift_i    (shift_en),
        .bit_i      (lnk.sda),
        .value_o    (cmd_val)
    );

    // pins are synchronous: one stage suffices for edge detection
    assign rise     = lnk.scl & ~q.scl;
    assign word     = {cmd_val[14:0], lnk.sda};
    assign cmd_bits = cmd_wide_i ? DSR_BITS_WIDE : DSR_BITS_NARROW;
    assign hit      = dsr_decode(word, cmd_wide_i);
    assign shift_en = rise && !lnk.csx_n &&
                      (q.st == DSR_DEV_IDLE || q.st == DSR_DEV_CMD);

    // settings, command reception and response shifting
    always_comb
    begin
        d     = q;
        d.scl = lnk.scl;

        // software reset restores defaults, else take writes
        if (sw_reset_i)
        begin
            d.pix = DSR_RST_PIXFMT;  // R3
            d.img = DSR_RST_IMGMODE; // R3
            d.sig = DSR_RST_SIGMODE; // R3
        end
        else if (set_valid_i)
        begin
            case (set_sel_i)
                DSR_SEL_PIXFMT:
                begin
                    if (dsr_fmt_ok(set_data_i[DSR_POS_COLFMT +: 3]))
                        d.pix = set_data_i & DSR_MASK_PIXFMT;    // R4
                end
                DSR_SEL_IMGMODE: d.img = set_data_i & DSR_MASK_IMGMODE; // R4
                DSR_SEL_SIGMODE: d.sig = set_data_i & DSR_MASK_SIGMODE; // R4
                default:         d.img = q.img;
            endcase
        end

        // no power-state gating anywhere below: sleep never blocks reads
        if (lnk.csx_n) // R11
        begin
            d.st   = DSR_DEV_IDLE;
            d.cnt  = 5'h00;
            d.resp = 8'h00;
        end
        else
        begin
            case (q.st)
                DSR_DEV_IDLE, DSR_DEV_CMD:
                begin
                    d.st = DSR_DEV_CMD;
                    if (rise)
                    begin
                        d.cnt = q.cnt + 5'h01;
                        if (q.cnt + 5'h01 == cmd_bits)
                        begin
                            d.cnt = 5'h00;
                            d.st  = DSR_DEV_RESP;
                            // current setting value, no dummy byte first
                            case (hit)                          // R12 R13
                                DSR_SEL_PIXFMT:  d.resp = q.pix;  // R2
                                DSR_SEL_IMGMODE: d.resp = q.img;  // R6 R7
                                DSR_SEL_SIGMODE: d.resp = q.sig;  // R9 R10
                                default:         d.st   = DSR_DEV_SKIP;
                            endcase
                        end
                    end
                end
                DSR_DEV_RESP:
                begin
                    // host samples on its own rising edge before we see it
                    if (rise)
                    begin
                        d.resp = {q.resp[6:0], 1'b0};
                        d.cnt  = q.cnt + 5'h01;
                        if (q.cnt + 5'h01 == DSR_BITS_PARAM)     // R12
                            d.st = DSR_DEV_SKIP;
                    end
                end
                DSR_DEV_SKIP:
                begin
                    d.resp = 8'h00; // extra clocks read zero
                end
                default:
                begin
                    d.st = DSR_DEV_IDLE;
                end
            endcase
        end
    end

    // power-on and hardware reset load the status defaults
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q.st   <= DSR_DEV_IDLE;
            q.scl  <= 1'b0;
            q.cnt  <= 5'h00;
            q.resp <= 8'h00;
            q.pix  <= DSR_RST_PIXFMT;  // R3
            q.img  <= DSR_RST_IMGMODE; // R3
            q.sig  <= DSR_RST_SIGMODE; // R3
        end
        else
        begin
            q <= d;
        end
    end

    // link output and settings straight from flops
    assign lnk.sdo                  = q.resp[7];
    assign interface_color_format_o = q.pix[DSR_POS_COLFMT +: 3]; // R2
    assign inversion_active_o       = q.img[DSR_POS_INV];         // R6
    assign force_white_active_o     = q.img[DSR_POS_WHITE];       // R6
    assign force_black_active_o     = q.img[DSR_POS_BLACK];       // R6
    assign gamma_curve_select_o     = q.img[DSR_POS_GAMMA +: 3];  // R7
    assign tear_line_enabled_o      = q.sig[DSR_POS_TEAR_LINE_ENABLED];        // R9
    assign tear_line_mode_o         = q.sig[DSR_POS_TEMODE];      // R10
    assign busy_o                   = (q.st != DSR_DEV_IDLE);
endmodule

// file: hw/dsr_host.sv
/*
 * Host controller: sends an AXI4-Lite command on the link, reports the
 * byte clocked back. Assumes one write and one read at a time at most.
 */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module dsr_host
    import dsr_pkg::*;
#(
    parameter int HALF = DSR_SCL_HALF
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link to the display
    dsr_link_if.host         lnk
);
    typedef struct packed {
        dsr_hst_st_type st;
        logic [7:0]     div;
        logic [4:0]     bits;
        logic [4:0]     nbits;
        logic [7:0]     rx;
        logic           wide;
        logic           done;
        logic           csx_n;
        logic           scl;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [1:0]     rresp;
        logic [31:0]    rdata;
    } dsr_host_type;

    dsr_host_type q, d;

    logic        wr_go;
    logic        rd_go;
    logic        start;
    logic        tx_shift;
    logic [15:0] tx_val;
    logic [15:0] tx_load;
    logic        half_end;

    // aw and w taken together, only with no response pending
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid & ~q.rvalid;
    assign s_axi_arready = ~q.rvalid;
    assign start         = wr_go && s_axi_awaddr == DSR_REG_CMD &&
                           s_axi_wstrb[0] && q.st == DSR_HST_IDLE;
    assign half_end      = (q.div == 8'(HALF - 1));
    assign tx_shift      = (q.st == DSR_HST_HIGH) && half_end;
    // an 8-bit command goes out from the top byte
    assign tx_load       = q.wide ? s_axi_wdata[15:0]
                                  : {s_axi_wdata[7:0], 8'h00};

    dsr_shift #(
        .W          (16)
    ) u_tx (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .load_i     (start),
        .load_val_i (tx_load),
        .shift_i    (tx_shift),
        .bit_i      (1'b0),
        .value_o    (tx_val)
    );

    // register access and link sequencing
    always_comb
    begin
        d = q;
        if (q.bvalid && s_axi_bready)
            d.bvalid = 1'b0;
        if (q.rvalid && s_axi_rready)
            d.rvalid = 1'b0;

        // writes: busy refuses a new command with slverr
        if (wr_go)
        begin
            d.bvalid = 1'b1;
            d.bresp  = DSR_RESP_OKAY;
            case (s_axi_awaddr)
                DSR_REG_CMD:
                    if (q.st != DSR_HST_IDLE)
                        d.bresp = DSR_RESP_SLVERR;
                DSR_REG_CFG:
                    if (s_axi_wstrb[0])
                        d.wide = s_axi_wdata[0];
                DSR_REG_STAT:
                    if (s_axi_wstrb[0] && s_axi_wdata[1])
                        d.done = 1'b0;
                default:
                    d.bresp = DSR_RESP_SLVERR;
            endcase
        end

        if (rd_go)
        begin
            d.rvalid = 1'b1;
            d.rresp  = DSR_RESP_OKAY;
            case (s_axi_araddr)
                DSR_REG_CFG:  d.rdata = {31'h0, q.wide};
                DSR_REG_STAT: d.rdata = {30'h0, q.done,
                                         q.st != DSR_HST_IDLE};
                DSR_REG_DATA: d.rdata = {24'h0, q.rx};
                DSR_REG_CMD:  d.rdata = 32'h0;
                default:
                begin
                    d.rdata = 32'h0;
                    d.rresp = DSR_RESP_SLVERR;
                end
            endcase
        end

        case (q.st)
            DSR_HST_IDLE:
            begin
                if (start)
                begin
                    d.csx_n = 1'b0;
                    d.div   = 8'h00;
                    d.bits  = 5'h00;
                    d.nbits = (q.wide ? DSR_BITS_WIDE : DSR_BITS_NARROW)
                              + DSR_BITS_PARAM;
                    d.st    = DSR_HST_LOW;
                end
            end
            DSR_HST_LOW:
            begin
                d.div = q.div + 8'h01;
                if (half_end)
                begin
                    d.div = 8'h00;
                    d.scl = 1'b1;
                    d.st  = DSR_HST_HIGH;
                    // one parameter byte follows the command directly
                    if (q.bits >= q.nbits - DSR_BITS_PARAM)     // R12
                        d.rx = {q.rx[6:0], lnk.sdo};
                end
            end
            DSR_HST_HIGH:
            begin
                d.div = q.div + 8'h01;
                if (half_end)
                begin
                    d.div  = 8'h00;
                    d.scl  = 1'b0;
                    d.bits = q.bits + 5'h01;
                    d.st   = DSR_HST_LOW;
                    if (q.bits + 5'h01 == q.nbits)              // R12
                    begin
                        d.csx_n = 1'b1;
                        d.st    = DSR_HST_IDLE;
                    end
                end
            end
            default:
                d.st = DSR_HST_IDLE;
        endcase

        // completion wins over a clear in the same cycle
        if (q.st == DSR_HST_HIGH && half_end && q.bits + 5'h01 == q.nbits)
            d.done = 1'b1;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q       <= '0;
            q.st    <= DSR_HST_IDLE;
            q.csx_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp  = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp  = q.rresp;
    assign s_axi_rdata  = q.rdata;
    assign lnk.csx_n    = q.csx_n;
    assign lnk.scl      = q.scl;
    assign lnk.sda      = tx_val[15];
endmodule

// file: hw/dsr_shift.sv
/*
 * Parameterised shift register, msb first, with synchronous load.
 * Assumes load has priority over shift.
 */
`timescale 1ns/100ps
module dsr_shift
    import dsr_pkg::*;
#(
    parameter int W = 16
)(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // control
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         shift_i,
    input  wire logic         bit_i,
    // contents
    output logic      [W-1:0] value_o
);
    typedef struct packed {
        logic [W-1:0] v;
    } dsr_shift_st_type;

    dsr_shift_st_type q, d;

    // load wins over shift
    always_comb
    begin
        d = q;
        if (load_i)
            d.v = load_val_i;
        else if (shift_i)
            d.v = {q.v[W-2:0], bit_i};
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            q <= '0;
        else
            q <= d;
    end

    assign value_o = q.v;
endmodule

// file: tb/dsr_link_sva.sv
/*
 * Assertions on the serial status link joining host and responder.
 * Assumes the host half period of 4 clocks and one clock domain.
 */
`timescale 1ns/100ps
module dsr_link_sva
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // link signals
    input  wire logic csx_n,
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic sdo
);
    logic       scl_q;
    logic [4:0] rise_q;

    default clocking dflt @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // count scl rises in a frame; cleared while deselected
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scl_q  <= 1'b0;
            rise_q <= 5'h00;
        end
        else
        begin
            scl_q <= scl;
            if (csx_n)
                rise_q <= 5'h00;
            else if (scl && !scl_q)
                rise_q <= rise_q + 5'h01;
        end
    end

    // framing and bit timing on the wire
    property p_idle_clk; csx_n |-> !scl; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("scl not idle");
    property p_start; $fell(csx_n) |-> !scl[*4] ##1 scl; endproperty
    a_start: assert property (p_start) else $error("bad frame start");
    property p_high; $rose(scl) |-> scl[*4] ##1 !scl; endproperty
    a_high: assert property (p_high) else $error("bad scl high time");
    property p_low; $fell(scl) && !csx_n |-> !scl[*4] ##1 scl; endproperty
    a_low: assert property (p_low) else $error("bad scl low time");
    property p_sda; scl |-> $stable(sda); endproperty
    a_sda: assert property (p_sda) else $error("sda moved, scl high");
    // reply bits move only while scl is high, csx_n is high, or csx_n was high a clock before
    property p_sdo_mv; $changed(sdo) |-> scl || csx_n || $past(csx_n);
    endproperty
    a_sdo_mv: assert property (p_sdo_mv) else $error("sdo moved");
    property p_sdo_idle; csx_n[*3] |-> !sdo; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo idle");
    // command bits plus exactly one parameter byte
    property p_len; $rose(csx_n) |-> rise_q == 5'h10 || rise_q == 5'h18;
    endproperty
    a_len: assert property (p_len) else $error("bad frame length");

    c_narrow: cover property ($rose(csx_n) && rise_q == 5'h10);
    c_wide: cover property ($rose(csx_n) && rise_q == 5'h18);
    c_reply: cover property (!csx_n && $rose(sdo));
endmodule

// file: tb/tb.sv
/*
 * Self-checking bench: both ends on one link, seeded random traffic.
 * Assumes the host keeps its default half period.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("wrong value %s exp %0h got %0h", nm, e, g); \
        end \
    end
module tb
    import dsr_pkg::*;
;
    logic        clk_i, nrst_i, wide, set_valid, sw_reset;
    logic [1:0]  set_sel, bresp, rresp;
    logic [7:0]  set_data;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic        awvalid, wvalid, arvalid;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [2:0]  icf, gam;
    logic        inv, wht, blk, tear_line_enabled, tem, busy;
    logic [7:0]  exp_st [3];
    logic [7:0]  cmd8 [3];
    int          fail_count, cmp_count;

    dsr_link_if lnk ();

    // ready lines held high: answers are taken at once
    dsr_host dsr_host_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .lnk(lnk));
    dsr_dev dsr_dev_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .lnk(lnk), .cmd_wide_i(wide),
        .set_valid_i(set_valid), .set_sel_i(set_sel),
        .set_data_i(set_data), .sw_reset_i(sw_reset),
        .interface_color_format_o(icf), .inversion_active_o(inv),
        .force_white_active_o(wht), .force_black_active_o(blk),
        .gamma_curve_select_o(gam), .tear_line_enabled_o(tear_line_enabled),
        .tear_line_mode_o(tem), .busy_o(busy));
    dsr_link_sva dsr_link_sva_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .csx_n(lnk.csx_n),
        .scl(lnk.scl), .sda(lnk.sda), .sdo(lnk.sdo));

    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // a wait that runs out ends the run as a mismatch
    task automatic guard(inout int n);
        n++;
        if (n > 3000)
        begin
            fail_count++;
            summarize();
        end
    endtask

    // handshakes looked at mid-cycle, where they are settled
    task automatic axw(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        int n = 0;
        awaddr  <= a;
        wdata   <= d;
        {awvalid, wvalid} <= 2'b11;
        do begin @(negedge clk_i); guard(n); end
        while ((awready & wready) !== 1'b1);
        @(posedge clk_i);
        {awvalid, wvalid} <= 2'b00;
        do begin @(negedge clk_i); guard(n); end while (bvalid !== 1'b1);
        r = bresp;
        @(posedge clk_i);
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin @(negedge clk_i); guard(n); end while (arready !== 1'b1);
        @(posedge clk_i);
        arvalid <= 1'b0;
        do begin @(negedge clk_i); guard(n); end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge clk_i);
    endtask

    // one read command over the link; bt also tries a second command
    task automatic rdst(input logic [15:0] c, input logic bt,
                        output logic [7:0] v);
        logic [31:0] d;
        logic [1:0]  r;
        int          n = 0;
        axw(DSR_REG_CMD, {16'h0, c}, r);
        if (bt)
        begin
            axw(DSR_REG_CMD, 32'h0000_000E, r);
            `CHK("busy write", {DSR_RESP_SLVERR, 1'b1}, {r, busy})
        end
        do begin axr(DSR_REG_STAT, d, r); guard(n); end while (d[1] !== 1'b1);
        `CHK("stat", 3'h4, {d[1:0], busy})
        axw(DSR_REG_STAT, 32'h0000_0002, r);
        axr(DSR_REG_DATA, d, r);
        v = d[7:0];
    endtask

    // expected bytes after a setting write or reset
    function automatic void upd(logic [1:0] s, logic [7:0] d, logic swr);
        if (swr)
            exp_st = '{8'h70, 8'h00, 8'h00};
        else if (s == 2'h0 && d[6:4] >= 3'h5)
            exp_st[0] = d & 8'h70;
        else if (s == 2'h1)
            exp_st[1] = d & 8'h3F;
        else if (s == 2'h2)
            exp_st[2] = d & 8'hC0;
    endfunction

    // software reset raised together with a write: reset wins
    task automatic put(input logic [1:0] s, input logic [7:0] d,
                       input logic swr);
        {set_valid, set_sel, set_data, sw_reset} <= {1'b1, s, d, swr};
        @(posedge clk_i);
        {set_valid, sw_reset} <= 2'b00;
        upd(s, d, swr);
        @(posedge clk_i);
    endtask

    task automatic setw(input logic b);
        logic [1:0] r;
        axw(DSR_REG_CFG, {31'h0, b}, r);
        wide <= b;
    endtask

    task automatic hw_reset();
        nrst_i <= 1'b0;
        wide   <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        exp_st = '{8'h70, 8'h00, 8'h00};
    endtask

    // all three bytes over the link, then the settings outputs
    task automatic chk_all();
        logic [7:0]  v;
        logic [10:0] s;
        for (int i = 0; i < 3; i++)
        begin
            rdst(wide ? {cmd8[i], 8'h00} : {8'h00, cmd8[i]}, 1'b0, v);
            `CHK("status byte", exp_st[i], v)
        end
        s = {exp_st[0][6:4], exp_st[1][5:0], exp_st[2][7:6]};
        `CHK("settings", s, {icf, inv, wht, blk, gam, tear_line_enabled, tem})
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // main sequence
    initial
    begin
        logic [7:0] v;
        fail_count = 0;
        cmp_count  = 0;
        {nrst_i, wide, set_valid, sw_reset, set_sel, set_data} = '0;
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
        cmd8 = '{8'h0C, 8'h0D, 8'h0E};
        void'($urandom(51));
        hw_reset();
        chk_all();
        // each colour format, then an undefined one
        for (int f = 5; f < 8; f++)
        begin
            put(2'h0, {1'b1, f[2:0], 4'hF}, 1'b0);
            chk_all();
        end
        put(2'h0, 8'h40, 1'b0);
        // random settings, random command form, rare software reset
        repeat (30)
        begin
            setw(1'($urandom));
            put(2'($urandom), 8'($urandom), $urandom_range(9) == 0);
            chk_all();
        end
        // second command during a frame, then an unknown command
        setw(1'b0);
        rdst(16'h000C, 1'b1, v);
        `CHK("byte after refusal", exp_st[0], v)
        rdst(16'h00FF, 1'b0, v);
        `CHK("unknown command", 8'h00, v)
        put(2'h3, 8'hFF, 1'b1);
        chk_all();
        put(2'h2, 8'hFF, 1'b0);
        hw_reset();
        chk_all();
        summarize();
    end
endmodule
